// file: rtl/vrh_pkg.sv
/*
 * Shared types and constants for the five-channel valid/ready host.
 * Assumes a single clock shared with the far slave; no software registers.
 */
package vrh_pkg;

	// ==========================================================
	// Widths
	localparam int ID_W   = 4;                 // Transaction tag
	localparam int ADDR_W = 32;                // Byte address
	localparam int LEN_W  = 4;                 // Beats minus one
	localparam int DATA_W = 32;                // Data bus
	localparam int STRB_W = DATA_W / 8;        // Byte lanes
	localparam int BEAT_W = LEN_W + 1;         // Beat counter

	// ==========================================================
	// Buffer and reset values
	localparam int          WD_FIFO_DEPTH = 32;   // Write data words
	localparam logic        VALID_RST     = 1'b0; // Sources idle low
	localparam logic        READY_RST     = 1'b0; // Sinks idle low
	localparam logic [1:0]  RESP_RST      = 2'h0; // Response field
	localparam logic [BEAT_W-1:0] BEAT_ONE = 5'h01; // Final beat

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic              write;  // 1 = write, 0 = read
		logic [ID_W-1:0]   id;     // Tag
		logic [ADDR_W-1:0] addr;   // Start address
		logic [LEN_W-1:0]  len;    // Beats minus one
		logic [2:0]        size;   // Bytes per beat code
		logic [1:0]        burst;  // Burst type code
	} vrh_cmd_t;

	typedef struct packed {
		logic [ID_W-1:0]   id;
		logic [ADDR_W-1:0] addr;
		logic [LEN_W-1:0]  len;
		logic [2:0]        size;
		logic [1:0]        burst;
	} vrh_addr_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;   // Write data
		logic [STRB_W-1:0] strb;   // Byte strobes
	} vrh_wbeat_t;

	typedef struct packed {
		logic [ID_W-1:0]   id;
		logic [DATA_W-1:0] data;
		logic [1:0]        resp;
		logic              last;
	} vrh_rbeat_t;

endpackage

// file: rtl/vrh_master.sv
/*
 * Write data FIFO and the host (master) end of a five-channel
 * valid/ready burst bus. Assumes the slave runs on sys_clk and keeps
 * its own handshake duties; one write or one read at a time, never both.
 */
`timescale 1ns/10ps

// ==============================================================
// Synchronous FIFO
module vrh_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// Drain side
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);
	// Index width from the depth
	localparam int PW = $clog2(DEPTH);

	// Whole buffer state in one record
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;      // Storage
		logic [PW-1:0]               wr_ptr;   // Fill index
		logic [PW-1:0]               rd_ptr;   // Drain index
		logic [PW:0]                 count;    // Words held
		logic                        not_full; // Registered room flag
	} vrh_fifo_st_t;

	vrh_fifo_st_t q, d;
	logic         push; // Word accepted
	logic         pop;  // Word removed

	// Flags and drain word come from registers
	assign in_ready  = q.not_full;
	assign out_valid = (q.count != '0);
	assign out_data  = q.mem[q.rd_ptr];
	assign push      = in_valid && q.not_full;
	assign pop       = out_ready && out_valid;

	// Next state
	always_comb begin
		d = q;
		// Accepted word goes in at the fill index
		if (push) begin
			d.mem[q.wr_ptr] = in_data;
			d.wr_ptr = (q.wr_ptr == PW'(DEPTH - 1)) ? '0 : q.wr_ptr + 1'b1;
		end
		// Drained word frees the slot at the drain index
		if (pop) begin
			d.rd_ptr = (q.rd_ptr == PW'(DEPTH - 1)) ? '0 : q.rd_ptr + 1'b1;
		end
		// Count and room flag follow both moves
		d.count = q.count + (PW+1)'(push) - (PW+1)'(pop);
		d.not_full = (d.count != (PW+1)'(DEPTH));
	end

	// State register
	// Asynchronous clear from the released reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// Empty, with room
			q <= '0;
			q.not_full <= 1'b1;
		end else begin
			q <= d;
		end
	end
endmodule

// ==============================================================
// Host end of the bus
// One write or one read in flight at most, never both together
module vrh_master #(
	parameter int WD_DEPTH = vrh_pkg::WD_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// User command
	input  wire logic              cmd_valid,
	input  wire vrh_pkg::vrh_cmd_t cmd,
	output logic                   cmd_ready,
	// User write data
	input  wire logic                wd_valid,
	input  wire vrh_pkg::vrh_wbeat_t wd,
	output logic                     wd_ready,
	// User write completion
	output logic                   wr_done,
	output logic [1:0]             wr_resp,
	// User read data
	output logic                   rd_valid,
	output vrh_pkg::vrh_rbeat_t    rd,
	input  wire logic              rd_ready,
	// Write address channel
	output logic                   awvalid,
	output vrh_pkg::vrh_addr_t     aw,
	input  wire logic              awready,
	// Write data channel
	output logic                   wvalid,
	output vrh_pkg::vrh_wbeat_t    w,
	output logic                   wlast,
	input  wire logic              wready,
	// Write response channel
	input  wire logic              bvalid,
	input  wire logic [vrh_pkg::ID_W-1:0] bid,
	input  wire logic [1:0]        bresp,
	output logic                   bready,
	// Read address channel
	output logic                   arvalid,
	output vrh_pkg::vrh_addr_t     ar,
	input  wire logic              arready,
	// Read data channel
	input  wire logic              rvalid,
	input  wire vrh_pkg::vrh_rbeat_t r,
	output logic                   rready
);

	// ==========================================================
	// State
	typedef struct packed {
		logic                        cmd_ready; // Can take a command
		logic                        awvalid;   // Write address offered
		vrh_pkg::vrh_addr_t          aw;        // Write address payload
		logic                        wvalid;    // Write beat offered
		vrh_pkg::vrh_wbeat_t         w;         // Write beat payload
		logic                        wlast;     // Final beat flag
		logic [vrh_pkg::BEAT_W-1:0]  w_left;    // Beats still to offer
		logic                        wr_busy;   // Write outstanding
		logic                        bready;    // Response sink ready
		logic                        wr_done;   // Completion pulse
		logic [1:0]                  wr_resp;   // Completion status
		logic                        arvalid;   // Read address offered
		vrh_pkg::vrh_addr_t          ar;        // Read address payload
		logic                        rd_busy;   // Read outstanding
		logic                        rready;    // Read sink ready
		logic                        rd_valid;  // User beat held
		vrh_pkg::vrh_rbeat_t         rd;        // User beat payload
	} vrh_st_t;

	// Registered state and its next value
	vrh_st_t q, d;

	logic               rst_s1_n, rst_s2_n; // Reset release stages
	logic               fifo_valid;         // Buffered beat present
	vrh_pkg::vrh_wbeat_t fifo_beat;         // Buffered beat
	logic               w_load;             // Take next beat
	logic               cmd_take;           // Command accepted

	// Shorten a command to its address payload
	// Shared by both address channels
	function automatic vrh_pkg::vrh_addr_t to_addr(
		input vrh_pkg::vrh_cmd_t c
	);
		to_addr = '{id: c.id, addr: c.addr, len: c.len,
			size: c.size, burst: c.burst};
	endfunction

	// ==========================================================
	// Reset release
	// Two stages so the core leaves reset on a clean edge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_n <= 1'b0;
			rst_s2_n <= 1'b0;
		end else begin
			rst_s1_n <= 1'b1;
			rst_s2_n <= rst_s1_n;
		end
	end

	// ==========================================================
	// Write data buffer; room flag is registered
	// Room flag is the user's write ready
	vrh_fifo #(
		.WIDTH ($bits(vrh_pkg::vrh_wbeat_t)),
		.DEPTH (WD_DEPTH)
	) u_wd_fifo (
		.clk       (sys_clk),
		.rst_n     (rst_s2_n),
		.in_valid  (wd_valid),
		.in_data   (wd),
		.in_ready  (wd_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_beat),
		.out_ready (w_load)
	);

	// Next beat loads when the slot is free or leaving this edge;
	// beats never wait for the address handshake
	assign w_load = (!q.wvalid || wready) && (q.w_left != '0)
		&& fifo_valid;
	// Commands only while both directions idle
	assign cmd_take = cmd_valid && q.cmd_ready;

	// ==========================================================
	// Next state
	always_comb begin
		d = q;
		// Completion pulse lasts one cycle
		d.wr_done = 1'b0;

		// New command: address, and for a write the beat budget, set in one go
		if (cmd_take) begin
			if (cmd.write) begin
				// Address, beat budget and response sink
				d.awvalid = 1'b1;
				d.aw      = to_addr(cmd);
				d.w_left  = {1'b0, cmd.len} + 1'b1;
				d.wr_busy = 1'b1;
				d.bready  = 1'b1;
			end else begin
				// Read sink follows from the busy flag
				d.arvalid = 1'b1;
				d.ar      = to_addr(cmd);
				d.rd_busy = 1'b1;
			end
		end

		// Write address holds until taken
		if (q.awvalid && awready) begin
			// Dropped only on the handshake edge
			d.awvalid = 1'b0;
		end

		// Write beats run apart from the address channel
		if (w_load) begin
			// Refill the slot; last flag on final beat
			d.wvalid = 1'b1;
			d.w      = fifo_beat;
			d.wlast  = (q.w_left == vrh_pkg::BEAT_ONE);
			d.w_left = q.w_left - 1'b1;
		end else if (q.wvalid && wready) begin
			// Slot empties: payload and strobes low
			d.wvalid = 1'b0;
			d.w      = '0;
			d.wlast  = 1'b0;
		end

		// Write response closes the write
		if (bvalid && q.bready) begin
			// Port frees for a new command next cycle
			d.bready  = 1'b0;
			d.wr_busy = 1'b0;
			d.wr_done = 1'b1;
			d.wr_resp = bresp;
		end

		// Read address holds until taken
		if (q.arvalid && arready) begin
			// Dropped only on the handshake edge
			d.arvalid = 1'b0;
		end

		// User drains its beat
		if (q.rd_valid && rd_ready) begin
			// Slot frees for the next bus beat
			d.rd_valid = 1'b0;
		end

		// Read beat captured only when the holding slot is empty
		if (rvalid && q.rready) begin
			d.rd_valid = 1'b1;
			d.rd       = r;
			if (r.last) begin
				// Final beat ends the read
				d.rd_busy = 1'b0;
			end
		end

		// Ready only while a read runs and the slot is free
		// Registered ready costs one idle cycle per beat
		d.rready = d.rd_busy && !d.rd_valid;

		// One write or one read at a time, never both
		// Next command once both directions finish
		d.cmd_ready = !d.wr_busy && !d.rd_busy;
	end

	// ==========================================================
	// State register
	always_ff @(posedge sys_clk or negedge rst_s2_n) begin
		if (!rst_s2_n) begin
			// Valids and readies start low
			q          <= '0;
			q.awvalid  <= vrh_pkg::VALID_RST;
			q.wvalid   <= vrh_pkg::VALID_RST;
			q.arvalid  <= vrh_pkg::VALID_RST;
			q.bready   <= vrh_pkg::READY_RST;
			q.rready   <= vrh_pkg::READY_RST;
			q.wr_resp  <= vrh_pkg::RESP_RST;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs straight from the state register
	// User side
	assign cmd_ready = q.cmd_ready;
	assign wr_done   = q.wr_done;
	assign wr_resp   = q.wr_resp;
	assign rd_valid  = q.rd_valid;
	assign rd        = q.rd;
	// Bus side; point to point, so beats reach only their slave
	assign awvalid   = q.awvalid;
	assign aw        = q.aw;
	assign wvalid    = q.wvalid;
	assign w         = q.w;
	assign wlast     = q.wlast;
	assign bready    = q.bready;
	assign arvalid   = q.arvalid;
	assign ar        = q.ar;
	assign rready    = q.rready;
endmodule

// file: verif/vrh_master_asserts.sv
/* Assertions on the host end of the five-channel bus.
   Bound to vrh_master; one clock, async active-low reset. */
`timescale 1ns/10ps
module vrh_master_asserts (
	// Clock, reset, user side
	input wire logic                sys_clk,
	input wire logic                rst_n,
	input wire logic                cmd_valid,
	input wire logic                cmd_ready,
	input wire logic                wr_done,
	// Bus channels
	input wire logic                awvalid,
	input wire vrh_pkg::vrh_addr_t  aw,
	input wire logic                awready,
	input wire logic                wvalid,
	input wire vrh_pkg::vrh_wbeat_t w,
	input wire logic                wlast,
	input wire logic                wready,
	input wire logic                bvalid,
	input wire logic                bready,
	input wire logic                arvalid,
	input wire vrh_pkg::vrh_addr_t  ar,
	input wire logic                arready,
	input wire logic                rvalid,
	input wire logic                rready
);
	// ==========================================
	// Clocking and helpers
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic took_q;	// Command taken on the last edge
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			took_q <= 1'b0;
		else
			took_q <= cmd_valid && cmd_ready;
	// Response handshake, then a one-cycle done pulse
	sequence s_b_hs;
		bvalid && bready;
	endsequence
	sequence s_done_pulse;
		wr_done ##1 !wr_done;
	endsequence
	// ==========================================
	// Properties
	a_aw_hold: assert property (
		awvalid && !awready |=> awvalid && $stable(aw))
		else $error("write address dropped early");
	a_ar_hold: assert property (
		arvalid && !arready |=> arvalid && $stable(ar))
		else $error("read address dropped early");
	a_w_hold: assert property (
		wvalid && !wready |=> wvalid && $stable({w, wlast}))
		else $error("write beat dropped early");
	a_strb_idle: assert property (
		!wvalid |-> w.strb == 4'h0)
		else $error("strobes set while idle");
	a_reset_quiet: assert property (
		$rose(rst_n) |-> (!awvalid && !wvalid && !arvalid) [*2])
		else $error("valid raised right after reset");
	a_resp_done: assert property (
		s_b_hs |=> s_done_pulse)
		else $error("done pulse missing after response");
	a_resp_wait: assert property (
		bready && !bvalid |=> bready)
		else $error("response ready dropped while waiting");
	a_read_take: assert property (
		rvalid && rready |=> !rready)
		else $error("read ready high while beat held");
	a_valid_cause: assert property (
		$rose(awvalid) || $rose(arvalid) |-> took_q)
		else $error("address valid without a command");
endmodule
bind vrh_master vrh_master_asserts u_chk (.*);

// file: verif/vrh_slave_model.sv
/* Behavioural slave for the five-channel bus.
   Assumes one write and one read in flight at a time. */
`timescale 1ns/10ps
module vrh_slave_model (
	// Clock, reset and knobs
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	input  wire logic                 slow,
	input  wire logic [1:0]           resp,
	output int                        werr,
	output vrh_pkg::vrh_wbeat_t       wseen,
	// Write channels
	input  wire logic                 awvalid,
	input  wire vrh_pkg::vrh_addr_t   aw,
	output logic                      awready,
	input  wire logic                 wvalid,
	input  wire vrh_pkg::vrh_wbeat_t  w,
	input  wire logic                 wlast,
	output logic                      wready,
	output logic                      bvalid,
	output logic [3:0]                bid,
	output logic [1:0]                bresp,
	input  wire logic                 bready,
	// Read channels
	input  wire logic                 arvalid,
	input  wire vrh_pkg::vrh_addr_t   ar,
	output logic                      arready,
	output logic                      rvalid,
	output vrh_pkg::vrh_rbeat_t       r,
	input  wire logic                 rready
);
	// ==========================================
	// State
	logic [3:0]          len_q, rlen_q, wcnt_q, rcnt_q, rid_q;
	logic [31:0]         rbase_q;	// Read start address
	logic                aw_ok_q, w_ok_q, rbusy_q;
	logic [3:0]          wlen;	// Burst length in force
	vrh_pkg::vrh_rbeat_t rv;	// Beat on offer
	assign wlen = awvalid ? aw.len : len_q;
	assign rv = '{rid_q, rbase_q + {28'h0, rcnt_q}, resp, rcnt_q == rlen_q};
	// Idle read beat and response code show the inverse, never a stale copy
	assign r = rvalid ? rv : ~rv;
	assign bresp = bvalid ? resp : ~resp;
	// ==========================================
	// Handshakes
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			{awready, wready, arready, bvalid, rvalid} <= 5'h0;
			{aw_ok_q, w_ok_q, rbusy_q} <= 3'h0;
			{len_q, rlen_q, wcnt_q, rcnt_q, rid_q, bid} <= 24'h0;
			rbase_q <= 32'h0;
			werr <= 0;
			wseen <= '0;
		end else begin
			// Readies idle high when fast, else answer a seen valid
			awready <= !slow || (awvalid && !awready);
			wready <= !slow || (wvalid && !wready);
			arready <= !slow || (arvalid && !arready);
			if (awvalid && awready) begin
				aw_ok_q <= 1'b1;
				len_q <= aw.len;
				bid <= aw.id;
			end
			if (wvalid && wready) begin
				wseen <= w;
				if (wlast !== (wcnt_q == wlen))
					werr <= werr + 1;
				wcnt_q <= wlast ? 4'h0 : wcnt_q + 4'h1;
				w_ok_q <= w_ok_q | wlast;
			end
			// Response only after address and final beat
			if (aw_ok_q && w_ok_q && !bvalid)
				bvalid <= 1'b1;
			if (bvalid && bready)
				{bvalid, aw_ok_q, w_ok_q} <= 3'h0;
			if (arvalid && arready) begin
				rbusy_q <= 1'b1;
				rbase_q <= ar.addr;
				rlen_q <= ar.len;
				rid_q <= ar.id;
				rcnt_q <= 4'h0;
			end
			// Data only for an accepted request
			if (rbusy_q && !rvalid)
				rvalid <= 1'b1;
			if (rvalid && rready) begin
				rvalid <= 1'b0;
				rcnt_q <= rcnt_q + 4'h1;
				rbusy_q <= !rv.last;
			end
		end
	end
endmodule

// file: verif/vrh_master_test.sv
/* Self-checking bench for vrh_master against the slave model.
   Assumes the checker is bound to the design by its own file. */
`timescale 1ns/10ps
module vrh_master_test;
	// ==========================================
	// Signals
	logic                sys_clk;
	logic                rst_n = 1'b0, cmd_valid = 1'b0;
	logic                wd_valid = 1'b0, rd_ready = 1'b0, slow = 1'b0;
	logic [1:0]          resp = 2'h0, wr_resp, bresp;
	vrh_pkg::vrh_cmd_t   cmd = '0;
	vrh_pkg::vrh_wbeat_t wd = 36'h0, w, wseen;
	vrh_pkg::vrh_rbeat_t rd, r;
	vrh_pkg::vrh_addr_t  aw, ar;
	logic [3:0]          bid;
	logic                cmd_ready, wd_ready, wr_done, rd_valid, wlast;
	logic                awvalid, awready, wvalid, wready, bvalid, bready;
	logic                arvalid, arready, rvalid, rready;
	int                  werr, errors = 0, total_checks = 0, cycles = 0;
	vrh_master u_dut (.*);
	vrh_slave_model u_slv (.*);
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// Hang guard
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			conclude;
		end
	end
	// ==========================================
	// Shared tasks
	task chk(input string what, input logic [31:0] exp, got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task send_cmd(input logic wr, input logic [3:0] len);
		cmd_valid <= 1'b1;
		cmd <= '{wr, 4'h3, 32'h1000, len, 3'h2, 2'h1};
		do @(posedge sys_clk); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
	endtask
	task push(input int n);
		for (int i = 0; i < n; i++) begin
			wd_valid <= 1'b1;
			wd <= '{32'ha500_0000 + i, 4'hf};
			do @(posedge sys_clk); while (wd_ready !== 1'b1);
		end
		wd_valid <= 1'b0;
	endtask
	// ==========================================
	// Scenarios
	task t_idle;
		chk("valids", 32'h0, {awvalid, wvalid, arvalid});
		repeat (4) @(posedge sys_clk);
		chk("command ready", 32'h1, cmd_ready);
	endtask
	task t_write(input logic [3:0] len, input logic [1:0] rc, input bit pre);
		logic [31:0] last_data;
		last_data = pre ? 32'ha500_0000 + len : 32'hb000_0000;
		resp <= rc;
		if (pre)
			push(len + 1);
		send_cmd(1'b1, len);
		do @(posedge sys_clk); while (wr_done !== 1'b1);
		chk("write response", rc, wr_resp);
		chk("last flag faults", 32'h0, werr);
		chk("write address", 32'h1000, aw.addr);
		chk("write length", len, aw.len);
		chk("last beat data", last_data, wseen.data);
		chk("last beat strobes", pre ? 4'hf : 4'h5, wseen.strb);
	endtask
	task t_read(input logic [3:0] len);
		rd_ready <= 1'b1;
		send_cmd(1'b0, len);
		for (int i = 0; i <= len; i++) begin
			do @(posedge sys_clk); while (rd_valid !== 1'b1);
			chk("read data", 32'h1000 + i, rd.data);
			chk("read last", i == len, rd.last);
			chk("read tag", 32'h3, rd.id);
			chk("read status", resp, rd.resp);
		end
	endtask
	task t_fill;
		int n;
		n = 0;
		slow <= 1'b1;
		wd_valid <= 1'b1;
		wd <= '{32'hb000_0000, 4'h5};
		repeat (40) begin
			@(posedge sys_clk);
			if (wd_ready === 1'b1)
				n++;
		end
		wd_valid <= 1'b0;
		chk("buffer depth", 32, n);
		chk("full refusal", 32'h0, wd_ready);
		t_write(4'hf, 2'h2, 1'b0);
		t_write(4'hf, 2'h1, 1'b0);
		chk("drained", 32'h1, wd_ready);
	endtask
	task conclude;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_idle;
		for (int k = 0; k < 4; k++) begin
			slow <= k[0];
			t_write(k[1] ? 4'hf : k[3:0], k[1:0], 1'b1);
		end
		slow <= 1'b0;
		t_read(4'h0);
		slow <= 1'b1;
		t_read(4'hf);
		t_fill;
		conclude;
	end
endmodule
